// ---- bfa_host.sv ----
module bfa_host (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         reqValid,
  input  wire bfa_pkg::bfa_op_t             reqOp,
  input  wire logic [2:0]                   reqSel,
  input  wire logic [bfa_pkg::SECT_W-1:0]   reqSector,
  input  wire logic                         byteMode,
  input  wire logic                         tempUnprotect,
  input  wire logic [7:0]                   lowByteDataLines,
  output logic                              reqReady,
  output logic                              respValid,
  output logic [7:0]                        respData,
  output logic                              respProtected,
  output logic                              respLocked,
  output logic [bfa_pkg::ADDR_W-1:0]        flashAddr,
  output logic                              addrLineNineHv,
  output logic                              resetHv,
  output logic                              chipSel_n,
  output logic                              outEn_n,
  output logic                              writeEn_n,
  output logic                              wordSel_n
);
  typedef enum logic [1:0] {IDLE, SETUP, STROBE, DONE} bfa_state_t;

  bfa_state_t                        state_r, state_nxt;
  logic [7:0]                        cnt_r, cnt_nxt;
  logic [bfa_pkg::ADDR_W-1:0]        addr_r, addr_nxt;
  logic                              hv_r, hv_nxt, oe_r, oe_nxt, ce_r, ce_nxt;
  logic                              rv_r, rv_nxt, rdy_r, rdy_nxt, rp_r, rp_nxt, lk_r, lk_nxt;
  logic [7:0]                        rd_r, rd_nxt;
  bfa_pkg::bfa_op_t                  op_r, op_nxt;
  logic [7:0]                        sync1_r, sync2_r;
  logic                              tu_r;
  logic                              weN_r, wordSel_r;
  logic [bfa_pkg::ADDR_W-1:0]        baseAddr;

  // Bottom-boot sector base in word units, lines 19..12 style
  function automatic logic [bfa_pkg::ADDR_W-1:0] sectBase(input logic [bfa_pkg::SECT_W-1:0] s);
    logic [bfa_pkg::ADDR_W-1:0] b;
    b = '0;
    if (s == 6'h00) b = 20'h00000;
    else if (s == 6'h01) b = 20'h02000;
    else if (s == 6'h02) b = 20'h03000;
    else if (s == 6'h03) b = 20'h04000;
    else b = {s[4:0] - 5'h03, 15'h0000};
    return b;
  endfunction

  // Pin data synchroniser
  always_ff @(posedge clock)
  begin
    sync1_r <= lowByteDataLines;
    sync2_r <= sync1_r;
    tu_r    <= rst_n ? tempUnprotect : 1'b0;
  end

  // Fixed strobes leave flops too, so no pin glitches through logic
  always_ff @(posedge clock)
  begin
    weN_r     <= 1'b1;   // No write cycles issued
    wordSel_r <= 1'b1;   // Word-wide bus
  end

  assign baseAddr = sectBase(reqSector);

  // Sequencer next values
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    hv_nxt    = hv_r;
    oe_nxt    = oe_r;
    ce_nxt    = ce_r;
    rv_nxt    = 1'b0;
    rdy_nxt   = rdy_r;
    rd_nxt    = rd_r;
    rp_nxt    = rp_r;
    lk_nxt    = lk_r;
    op_nxt    = op_r;
    case (state_r)
      IDLE:
      begin
        if (reqValid && rdy_r)
        begin
          op_nxt   = reqOp;
          rdy_nxt  = 1'b0;
          addr_nxt = '0;
          addr_nxt[bfa_pkg::LINE_SIX]  = reqSel[2];
          addr_nxt[bfa_pkg::LINE_ONE]  = reqSel[1];
          addr_nxt[bfa_pkg::LINE_ZERO] = reqSel[0];
          if (reqOp == bfa_pkg::OP_PROTECT_VERIFY)
          begin
            addr_nxt[bfa_pkg::ADDR_W-1:bfa_pkg::SECT_LSB] = baseAddr[bfa_pkg::ADDR_W-1:bfa_pkg::SECT_LSB];
            addr_nxt[bfa_pkg::LINE_ONE]  = 1'b1;
            addr_nxt[bfa_pkg::LINE_ZERO] = 1'b0;
          end
          else if (reqOp == bfa_pkg::OP_LOCK_READ)
          begin
            addr_nxt[bfa_pkg::LINE_ONE]  = 1'b1;
            addr_nxt[bfa_pkg::LINE_ZERO] = 1'b1;
          end
          else if (reqOp == bfa_pkg::OP_SECTOR_ADDR)
            addr_nxt = baseAddr;
          hv_nxt    = (reqOp != bfa_pkg::OP_SECTOR_ADDR);
          ce_nxt    = 1'b0;
          cnt_nxt   = 8'(bfa_pkg::STROBE_CYC);
          state_nxt = SETUP;
        end
      end
      SETUP:
      begin
        if (cnt_r == 8'h00)
        begin
          oe_nxt    = 1'b0;
          cnt_nxt   = 8'(bfa_pkg::STROBE_CYC + 2);
          state_nxt = STROBE;
        end
        else
          cnt_nxt = cnt_r - 8'h01;
      end
      STROBE:
      begin
        if (cnt_r == 8'h00)
        begin
          rd_nxt    = sync2_r;
          rp_nxt    = (sync2_r == bfa_pkg::PROT_YES);
          lk_nxt    = sync2_r[bfa_pkg::LOCK_BIT];
          oe_nxt    = 1'b1;
          ce_nxt    = 1'b1;
          hv_nxt    = 1'b0;
          rv_nxt    = 1'b1;
          state_nxt = DONE;
        end
        else
          cnt_nxt = cnt_r - 8'h01;
      end
      DONE:
      begin
        rdy_nxt   = 1'b1;
        state_nxt = IDLE;
      end
      default: state_nxt = IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r <= IDLE;
      cnt_r   <= 8'h00;
      addr_r  <= '0;
      hv_r    <= 1'b0;
      oe_r    <= 1'b1;
      ce_r    <= 1'b1;
      rv_r    <= 1'b0;
      rdy_r   <= 1'b1;
      rd_r    <= 8'h00;
      rp_r    <= 1'b0;
      lk_r    <= 1'b0;
      op_r    <= bfa_pkg::OP_READ_ID;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      hv_r    <= hv_nxt;
      oe_r    <= oe_nxt;
      ce_r    <= ce_nxt;
      rv_r    <= rv_nxt;
      rdy_r   <= rdy_nxt;
      rd_r    <= rd_nxt;
      rp_r    <= rp_nxt;
      lk_r    <= lk_nxt;
      op_r    <= op_nxt;
    end
  end

  assign reqReady       = rdy_r;
  assign respValid      = rv_r;
  assign respData       = rd_r;
  assign respProtected  = rp_r;
  assign respLocked     = lk_r;
  assign flashAddr      = addr_r;
  assign addrLineNineHv = hv_r;
  assign resetHv        = tu_r;
  assign chipSel_n      = ce_r;
  assign outEn_n        = oe_r;
  assign writeEn_n      = weN_r;
  assign wordSel_n      = wordSel_r;

  // Read strobes other than sector address ones only while high voltage is on line nine
  hv_during_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == STROBE && op_r != bfa_pkg::OP_SECTOR_ADDR) |-> (hv_r && !ce_r && !oe_r))
    else $error("autoselect read without high voltage");
  verify_sector_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == STROBE && op_r == bfa_pkg::OP_PROTECT_VERIFY) |-> (addr_r[1:0] == 2'h2))
    else $error("protect verify pattern wrong");
  resp_follows_strobe_a: assert property (@(posedge clock) disable iff (!rst_n)
    respValid |-> $past(state_r) == STROBE)
    else $error("response without strobe");
  prot_flag_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    respValid |-> (respProtected == (respData == bfa_pkg::PROT_YES)))
    else $error("protect flag mismatch");
  lock_flag_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    respValid |-> (respLocked == respData[7]))
    else $error("lock flag mismatch");
  ready_return_a: assert property (@(posedge clock) disable iff (!rst_n)
    respValid |=> reqReady)
    else $error("ready not restored");
  hv_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    respValid |-> !addrLineNineHv)
    else $error("high voltage left on");
  temp_unprot_a: assert property (@(posedge clock) disable iff (!rst_n)
    tempUnprotect |=> resetHv)
    else $error("temporary unprotect not driven");
  idle_pins_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == IDLE) |-> (chipSel_n && outEn_n && !addrLineNineHv))
    else $error("strobes active while idle");
endmodule

// ---- bfa_pkg.sv ----
// What this block does
// - Host holds chip and output enable low, write high, and line nine at high voltage except for sector address requests.
// - Protect verify places the sector address on the top address lines.
// - Temporary unprotect request drives the reset pin at high voltage, one clock later.
package bfa_pkg;
  localparam int       NUM_SECTORS   = 35;
  localparam int       ADDR_W        = 20;
  localparam int       SECT_W        = 6;
  // Cycles of the setup phase count; the strobe phase count is two more
  localparam int       STROBE_NS     = 100;
  localparam int       CLK_NS        = 50;
  localparam int       STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Autoselect selection on lines six, one, zero
  localparam logic [2:0] SEL_MAKER   = 3'h0;
  localparam logic [2:0] SEL_DEVICE  = 3'h1;
  localparam logic [2:0] SEL_PROTECT = 3'h2;
  localparam logic [2:0] SEL_LOCKIND = 3'h3;
  localparam logic [7:0] PROT_YES    = 8'h01;
  localparam logic [7:0] PROT_NO     = 8'h00;
  localparam logic [7:0] LOCK_YES    = 8'h83;
  localparam logic [7:0] LOCK_NO     = 8'h03;
  localparam int       LOCK_BIT      = 7;
  // Bit positions of the selection lines, line nine and the sector field inside the address
  localparam int       LINE_ZERO     = 0;
  localparam int       LINE_ONE      = 1;
  localparam int       LINE_SIX      = 6;
  localparam int       LINE_NINE     = 9;
  localparam int       SECT_LSB      = 12;
  typedef enum logic [1:0] {OP_READ_ID, OP_PROTECT_VERIFY, OP_LOCK_READ, OP_SECTOR_ADDR} bfa_op_t;
endpackage

// ---- bfa_flash_model.sv ----
module bfa_flash_model #(
  parameter logic [7:0]  MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0]  DEV_CODE   = 8'ha5, // Arbitrary value
  parameter logic [34:0] SHIP_PROT  = 35'h0,
  parameter bit          LOCKED     = 1'b1
) (
  input  wire logic [19:0] addr,
  input  wire logic        nineHv,
  input  wire logic        resetHv,
  input  wire logic        chipSel_n,
  input  wire logic        outEn_n,
  input  wire logic        writeEn_n,
  output logic [7:0]       dataOut
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [34:0] protFlag = SHIP_PROT;
  logic [34:0] writable;
  logic [5:0]  sect;
  logic [7:0]  code;
  logic [7:0]  lastV = 8'h00;
  logic        active;
  // Sector from the top address lines, bottom boot map
  always_comb
  begin
    if (addr[19:15] != 5'h00) sect = 6'(addr[19:15]) + 6'h03;
    else if (addr[14]) sect = 6'h03;
    else if (addr[13]) sect = addr[12] ? 6'h02 : 6'h01;
    else sect = 6'h00;
  end
  // Program and erase acceptance per sector
  assign writable = ~protFlag | {35{resetHv}};
  assign active = nineHv && !chipSel_n && !outEn_n && writeEn_n;
  // Identifier selected by lines six, one, zero
  always_comb
  begin
    case ({addr[6], addr[1], addr[0]})
      3'h0: code = MAKER_CODE;
      3'h1: code = DEV_CODE;
      3'h2: code = protFlag[sect] ? bfa_pkg::PROT_YES : bfa_pkg::PROT_NO;
      3'h3: code = LOCKED ? bfa_pkg::LOCK_YES : bfa_pkg::LOCK_NO;
      default: code = 8'h00;
    endcase
  end
  // Released lines show the inverse of the last value
  always @(*) if (active) lastV = code;
  assign dataOut = active ? code : ~lastV;
endmodule

// ---- test_boot_flash_autoselect_protect.sv ----
module test_boot_flash_autoselect_protect;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0]  DEVC  = 8'ha5; // Arbitrary value
  localparam logic [34:0] PROT  = 35'h400000002;
  logic clock = 0, rst_n = 0, reqValid = 0, byteMode = 0, tempUnprotect = 0;
  bfa_pkg::bfa_op_t reqOp = bfa_pkg::OP_READ_ID;
  logic [2:0]  reqSel = 3'h0;
  logic [5:0]  reqSector = 6'h00;
  logic [7:0]  dq, respData;
  logic [19:0] flashAddr, addrSeen;
  logic        reqReady, respValid, respProtected, respLocked, nineHv, resetHv, chipSel_n, outEn_n, writeEn_n;
  logic        wordSel_n;
  int          error_cnt = 0, check_count = 0, cycles = 0;
  initial forever #25 clock = ~clock;
  bfa_host bfa_host_inst (.clock(clock), .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp), .reqSel(reqSel),
    .reqSector(reqSector), .byteMode(byteMode), .tempUnprotect(tempUnprotect), .lowByteDataLines(dq),
    .reqReady(reqReady), .respValid(respValid), .respData(respData), .respProtected(respProtected),
    .respLocked(respLocked), .flashAddr(flashAddr), .addrLineNineHv(nineHv), .resetHv(resetHv),
    .chipSel_n(chipSel_n), .outEn_n(outEn_n), .writeEn_n(writeEn_n), .wordSel_n(wordSel_n));
  bfa_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVC), .SHIP_PROT(PROT), .LOCKED(1'b1)) bfa_flash_model_inst (
    .addr(flashAddr), .nineHv(nineHv), .resetHv(resetHv), .chipSel_n(chipSel_n), .outEn_n(outEn_n),
    .writeEn_n(writeEn_n), .dataOut(dq));
  // Cut a hang short
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic tally(string n, logic [19:0] e, logic [19:0] s);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chkData(string n, logic [7:0] e, logic [7:0] s);
    tally(n, 20'(e), 20'(s));
  endtask
  task automatic chkFlag(string n, logic e, logic s);
    tally(n, 20'(e), 20'(s));
  endtask
  task automatic chkAddr(string n, logic [19:0] e, logic [19:0] s);
    tally(n, e, s);
  endtask
  // One request, held until taken, answer seen on its pulse
  task automatic request(bfa_pkg::bfa_op_t op, logic [2:0] sel, int sect);
    int n;
    @(posedge clock);
    reqOp <= op;
    reqSel <= sel;
    reqSector <= 6'(sect);
    reqValid <= 1'b1;
    n = 0;
    @(negedge clock);
    while (reqReady !== 1'b1 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    reqValid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end while (respValid !== 1'b1 && n < 30);
    addrSeen = flashAddr;
    // Setup and strobe counters run from the taking edge, pulse seen one edge later
    chkData("answer latency", 8'(2 * bfa_pkg::STROBE_CYC + 5), 8'(n));
  endtask
  function automatic logic [19:0] base(int s);
    return s == 0 ? 20'h00000 : s == 1 ? 20'h02000 : s == 2 ? 20'h03000 : s == 3 ? 20'h04000 : 20'(s - 3) << 15;
  endfunction
  task automatic test_ident();
    request(bfa_pkg::OP_READ_ID, bfa_pkg::SEL_MAKER, 0);
    chkData("maker code", MAKER, respData);
    request(bfa_pkg::OP_READ_ID, bfa_pkg::SEL_DEVICE, 0);
    chkData("device code", DEVC, respData);
    chkFlag("word select", 1'b1, wordSel_n);
    chkFlag("write enable", 1'b1, writeEn_n);
    $display("test_ident done");
  endtask
  task automatic test_protect();
    int list[7] = '{0, 1, 2, 3, 4, 33, 34};
    foreach (list[i])
    begin
      request(bfa_pkg::OP_PROTECT_VERIFY, bfa_pkg::SEL_PROTECT, list[i]);
      chkFlag("protected", PROT[list[i]], respProtected);
      chkData("verify byte", PROT[list[i]] ? bfa_pkg::PROT_YES : bfa_pkg::PROT_NO, respData);
    end
    $display("test_protect done");
  endtask
  task automatic test_lock();
    request(bfa_pkg::OP_LOCK_READ, bfa_pkg::SEL_LOCKIND, 0);
    chkFlag("locked", 1'b1, respLocked);
    chkData("lock byte", bfa_pkg::LOCK_YES, respData);
    $display("test_lock done");
  endtask
  task automatic test_sector_addr();
    for (int s = 0; s < bfa_pkg::NUM_SECTORS; s++)
    begin
      request(bfa_pkg::OP_SECTOR_ADDR, 3'h0, s);
      chkAddr("sector base", base(s), addrSeen);
    end
    $display("test_sector_addr done");
  endtask
  task automatic test_temp();
    @(posedge clock);
    tempUnprotect <= 1'b1;
    repeat (3) @(negedge clock);
    chkFlag("reset pin high voltage", 1'b1, resetHv);
    @(posedge clock);
    tempUnprotect <= 1'b0;
    repeat (3) @(negedge clock);
    chkFlag("reset pin released", 1'b0, resetHv);
    $display("test_temp done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    test_ident();
    test_protect();
    test_lock();
    test_sector_addr();
    test_temp();
    stop_test();
  end
endmodule
